// file: shared/tcsdma_defs.svh
// Register offsets, field positions and reset values of the two-channel DMA
`ifndef TCSDMA_DEFS_SVH
`define TCSDMA_DEFS_SVH
// Register byte offsets (printed offsets are not all multiples of 4 -> index*4)
`define TCSDMA_CAUSE0_IDX 12'h3b8
`define TCSDMA_CAUSE1_IDX 12'h3ba
`define TCSDMA_CAUSE0_ADDR 14'h0ee0
`define TCSDMA_CAUSE1_ADDR 14'h0ee8
`define TCSDMA_CTRL0_ADDR 14'h0f00
`define TCSDMA_CTRL1_ADDR 14'h0f04
`define TCSDMA_SRC0_ADDR 14'h0f08
`define TCSDMA_SRC1_ADDR 14'h0f0c
`define TCSDMA_DST0_ADDR 14'h0f10
`define TCSDMA_DST1_ADDR 14'h0f14
`define TCSDMA_RLD0_ADDR 14'h0f18
`define TCSDMA_RLD1_ADDR 14'h0f1c
`define TCSDMA_CNT0_ADDR 14'h0f20
`define TCSDMA_CNT1_ADDR 14'h0f24
// Cause register fields
`define TCSDMA_SEL_LSB 0
`define TCSDMA_SEL_MSB 3
`define TCSDMA_EXT_BIT 6
`define TCSDMA_SOFT_BIT 7
`define TCSDMA_SOFT_CODE 4'h1
// Control register fields
`define TCSDMA_UNIT_BIT 0
`define TCSDMA_RPT_BIT 1
`define TCSDMA_PEND_BIT 2
`define TCSDMA_EN_BIT 3
`define TCSDMA_SSTEP_BIT 4
`define TCSDMA_DSTEP_BIT 5
// Reset values and widths
`define TCSDMA_RST_BYTE 8'h00
`define TCSDMA_RST_ADDR 20'h00000
`define TCSDMA_RST_CNT 16'h0000
`define TCSDMA_CNT_ZERO 16'h0000
`define TCSDMA_WORD_STEP 20'h00002
`define TCSDMA_BYTE_STEP 20'h00001
`endif

// file: shared/tcsdma_pkg.sv
// Types shared by the two-channel cycle-steal DMA
package tcsdma_pkg;
    // Phases of one stolen transfer
    typedef enum logic [1:0] {
        TCSDMA_IDLE,
        TCSDMA_READ,
        TCSDMA_WRITE
    } tcsdma_phase_type;

    // Per-channel configuration and live state
    typedef struct packed {
        logic [7:0] cause;
        logic unit_size_select;
        logic repeat_mode_select;
        logic request_pending_bit;
        logic channel_enable;
        logic source_step_select;
        logic dest_step_select;
        logic fresh;
        logic [19:0] src;
        logic [19:0] dst;
        logic [15:0] reload;
        logic [15:0] count;
        logic [19:0] fwd;
    } tcsdma_chan_type;

    // Shared system bus request toward memory
    typedef struct packed {
        logic req;
        logic wr;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic byte_mode;
    } tcsdma_sbus_type;

    // Whole state of the controller
    typedef struct packed {
        tcsdma_chan_type [1:0] ch;
        tcsdma_phase_type phase;
        logic chan;
        logic [15:0] data;
        logic [1:0] irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tcsdma_state_type;
endpackage

// file: verilog/tcsdma_core.sv
// Two-channel cycle-steal DMA controller with APB register access
`timescale 1ns/1ps
`include "tcsdma_defs.svh"
module tcsdma_core
    import tcsdma_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [13:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Peripheral request lines, basic and extended set per channel
    input wire logic [15:0] ch0_basic_in,
    input wire logic [15:0] ch0_ext_in,
    input wire logic [15:0] ch1_basic_in,
    input wire logic [15:0] ch1_ext_in,
    // Shared system bus
    output logic bus_req_out,
    output logic bus_wr_out,
    output logic [19:0] bus_addr_out,
    output logic [15:0] bus_wdata_out,
    output logic bus_byte_out,
    input wire logic bus_grant_in,
    input wire logic bus_done_in,
    input wire logic [15:0] bus_rdata_in,
    // Channel interrupt requests
    output logic [1:0] dma_irq_out
);

    // ------------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------------
    logic [63:0] src_meta;
    logic [63:0] src_sync;
    logic [63:0] src_prev;

    // Two flops before any use; previous copy for edge detection
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            src_meta <= 64'h0;
            src_sync <= 64'h0;
            src_prev <= 64'h0;
        end else begin
            src_meta <= {ch1_ext_in, ch1_basic_in, ch0_ext_in, ch0_basic_in};
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    // Rising edge on any request line is one event; interrupt masks never
    // reach this logic, and nothing here writes back to a source flag
    logic [63:0] src_evt;
    assign src_evt = src_sync & ~src_prev;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tcsdma_state_type st;
    tcsdma_state_type next_st;
    tcsdma_sbus_type sbus;

    logic apb_wr;
    logic apb_rd;
    // Writes land on the edge where the master sees pready high, so a
    // soft request is taken once and cannot re-arm after its own grant
    assign apb_wr = psel_in && penable_in && pwrite_in && st.pready;
    assign apb_rd = psel_in && penable_in && !pwrite_in;

    // Selected request per channel
    logic [1:0] sel_evt;
    logic [1:0] soft_evt;
    logic [1:0] wr_cause;
    logic [1:0] wr_ctrl;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_req
            logic [3:0] code;
            logic ext;
            assign code = st.ch[gi].cause[`TCSDMA_SEL_MSB:`TCSDMA_SEL_LSB];
            assign ext = st.ch[gi].cause[`TCSDMA_EXT_BIT];
            // Extended or basic table; codes without a source read low
            assign sel_evt[gi] = ext ? src_evt[32*gi+16+code]
                                     : src_evt[32*gi+code];
            assign wr_cause[gi] = apb_wr && paddr_in ==
                (gi == 0 ? `TCSDMA_CAUSE0_ADDR : `TCSDMA_CAUSE1_ADDR);
            assign wr_ctrl[gi] = apb_wr && paddr_in ==
                (gi == 0 ? `TCSDMA_CTRL0_ADDR : `TCSDMA_CTRL1_ADDR);
            // Soft bit counts only with basic set and code 0001b
            assign soft_evt[gi] = wr_cause[gi] && pwdata_in[`TCSDMA_SOFT_BIT]
                && !pwdata_in[`TCSDMA_EXT_BIT]
                && pwdata_in[`TCSDMA_SEL_MSB:`TCSDMA_SEL_LSB] == `TCSDMA_SOFT_CODE;
        end
    endgenerate

    // Channel 0 wins when both wait
    logic [1:0] ready_ch;
    logic grant_any;
    logic grant_ch;
    assign ready_ch[0] = st.ch[0].request_pending_bit && st.ch[0].channel_enable;
    assign ready_ch[1] = st.ch[1].request_pending_bit && st.ch[1].channel_enable;
    assign grant_any = st.phase == TCSDMA_IDLE && |ready_ch;
    assign grant_ch = !ready_ch[0];

    // Read mux
    function automatic logic [31:0] read_reg(input tcsdma_state_type s,
                                             input logic [13:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            // Soft bit reads zero, b5-b4 are never stored
            `TCSDMA_CAUSE0_ADDR: r = {24'h0, 1'b0, s.ch[0].cause[`TCSDMA_EXT_BIT], 2'b00,
                s.ch[0].cause[`TCSDMA_SEL_MSB:`TCSDMA_SEL_LSB]};
            `TCSDMA_CAUSE1_ADDR: r = {24'h0, 1'b0, s.ch[1].cause[`TCSDMA_EXT_BIT], 2'b00,
                s.ch[1].cause[`TCSDMA_SEL_MSB:`TCSDMA_SEL_LSB]};
            `TCSDMA_CTRL0_ADDR: r = {26'h0, s.ch[0].dest_step_select,
                s.ch[0].source_step_select, s.ch[0].channel_enable,
                s.ch[0].request_pending_bit, s.ch[0].repeat_mode_select,
                s.ch[0].unit_size_select};
            `TCSDMA_CTRL1_ADDR: r = {26'h0, s.ch[1].dest_step_select,
                s.ch[1].source_step_select, s.ch[1].channel_enable,
                s.ch[1].request_pending_bit, s.ch[1].repeat_mode_select,
                s.ch[1].unit_size_select};
            `TCSDMA_SRC0_ADDR: r = {12'h0, s.ch[0].source_step_select ? s.ch[0].fwd
                                                                  : s.ch[0].src};
            `TCSDMA_SRC1_ADDR: r = {12'h0, s.ch[1].source_step_select ? s.ch[1].fwd
                                                                  : s.ch[1].src};
            `TCSDMA_DST0_ADDR: r = {12'h0, s.ch[0].dest_step_select ? s.ch[0].fwd
                                                                : s.ch[0].dst};
            `TCSDMA_DST1_ADDR: r = {12'h0, s.ch[1].dest_step_select ? s.ch[1].fwd
                                                                : s.ch[1].dst};
            `TCSDMA_RLD0_ADDR: r = {16'h0, s.ch[0].reload};
            `TCSDMA_RLD1_ADDR: r = {16'h0, s.ch[1].reload};
            `TCSDMA_CNT0_ADDR: r = {16'h0, s.ch[0].count};
            `TCSDMA_CNT1_ADDR: r = {16'h0, s.ch[1].count};
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    function automatic logic mapped(input logic [13:0] a);
        logic m;
        m = 1'b0;
        case (a)
            `TCSDMA_CAUSE0_ADDR, `TCSDMA_CAUSE1_ADDR, `TCSDMA_CTRL0_ADDR,
            `TCSDMA_CTRL1_ADDR, `TCSDMA_SRC0_ADDR, `TCSDMA_SRC1_ADDR,
            `TCSDMA_DST0_ADDR, `TCSDMA_DST1_ADDR, `TCSDMA_RLD0_ADDR,
            `TCSDMA_RLD1_ADDR, `TCSDMA_CNT0_ADDR, `TCSDMA_CNT1_ADDR: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic c;
        logic [19:0] step;
        logic under;
        c = st.chan;
        step = `TCSDMA_WORD_STEP;
        under = 1'b0;
        next_st = st;
        next_st.irq = 2'b00;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;

        // APB answers one cycle after the access phase begins
        if (psel_in && penable_in && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !mapped(paddr_in);
            next_st.prdata = apb_rd ? read_reg(st, paddr_in) : 32'h0;
        end

        for (int i = 0; i < 2; i++) begin
            if (wr_cause[i]) begin
                next_st.ch[i].cause = {2'b00, 2'b00,
                    pwdata_in[`TCSDMA_SEL_MSB:`TCSDMA_SEL_LSB]} |
                    ({7'h0, pwdata_in[`TCSDMA_EXT_BIT]} << `TCSDMA_EXT_BIT);
            end
            if (wr_ctrl[i]) begin
                next_st.ch[i].unit_size_select = pwdata_in[`TCSDMA_UNIT_BIT];
                next_st.ch[i].repeat_mode_select = pwdata_in[`TCSDMA_RPT_BIT];
                next_st.ch[i].channel_enable = pwdata_in[`TCSDMA_EN_BIT];
                next_st.ch[i].source_step_select = pwdata_in[`TCSDMA_SSTEP_BIT];
                next_st.ch[i].dest_step_select = pwdata_in[`TCSDMA_DSTEP_BIT];
                // Writing 1 to enable re-arms the reload on next transfer
                next_st.ch[i].fresh = pwdata_in[`TCSDMA_EN_BIT];
                // Pending may be cleared by a control write, never set by one
                if (!pwdata_in[`TCSDMA_PEND_BIT]) begin
                    next_st.ch[i].request_pending_bit = 1'b0;
                end
            end
            if (apb_wr) begin
                if (paddr_in == (i == 0 ? `TCSDMA_SRC0_ADDR : `TCSDMA_SRC1_ADDR)) begin
                    next_st.ch[i].src = pwdata_in[19:0];
                end
                if (paddr_in == (i == 0 ? `TCSDMA_DST0_ADDR : `TCSDMA_DST1_ADDR)) begin
                    next_st.ch[i].dst = pwdata_in[19:0];
                end
                if (paddr_in == (i == 0 ? `TCSDMA_RLD0_ADDR : `TCSDMA_RLD1_ADDR)) begin
                    next_st.ch[i].reload = pwdata_in[15:0];
                end
            end
            // Grant clears the latch; new event wins over the clear; extra
            // events during a transfer merge into the one latch
            if (grant_any && grant_ch == i[0]) begin
                next_st.ch[i].request_pending_bit = 1'b0;
            end
            if (sel_evt[i] || soft_evt[i]) begin
                next_st.ch[i].request_pending_bit = 1'b1;
            end
        end

        case (st.phase)
            TCSDMA_IDLE: begin
                if (grant_any) begin
                    next_st.chan = grant_ch;
                    next_st.phase = TCSDMA_READ;
                    if (st.ch[grant_ch].fresh) begin
                        next_st.ch[grant_ch].fresh = 1'b0;
                        next_st.ch[grant_ch].count = st.ch[grant_ch].reload;
                        next_st.ch[grant_ch].fwd = st.ch[grant_ch].source_step_select
                            ? st.ch[grant_ch].src : st.ch[grant_ch].dst;
                    end
                end
            end
            TCSDMA_READ: begin
                if (bus_done_in) begin
                    next_st.data = bus_rdata_in;
                    next_st.phase = TCSDMA_WRITE;
                end
            end
            TCSDMA_WRITE: begin
                if (bus_done_in) begin
                    next_st.phase = TCSDMA_IDLE;
                    step = st.ch[c].unit_size_select ? `TCSDMA_BYTE_STEP
                                                     : `TCSDMA_WORD_STEP;
                    next_st.ch[c].fwd = st.ch[c].fwd + step;
                    under = st.ch[c].count == `TCSDMA_CNT_ZERO;
                    next_st.ch[c].count = st.ch[c].count - 16'h0001;
                    if (under) begin
                        next_st.irq[c] = 1'b1;
                        if (st.ch[c].repeat_mode_select) begin
                            next_st.ch[c].count = st.ch[c].reload;
                        end else begin
                            next_st.ch[c].channel_enable = 1'b0;
                        end
                    end
                end
            end
            default: next_st.phase = TCSDMA_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Bus request toward the shared bus
    // ------------------------------------------------------------------
    // The arbiter outside gives this request priority over the CPU
    always_comb begin
        sbus.req = st.phase != TCSDMA_IDLE;
        sbus.wr = st.phase == TCSDMA_WRITE;
        sbus.byte_mode = st.ch[st.chan].unit_size_select;
        sbus.wdata = st.data;
        if (st.phase == TCSDMA_READ) begin
            sbus.addr = st.ch[st.chan].source_step_select ? st.ch[st.chan].fwd
                                                          : st.ch[st.chan].src;
        end else begin
            sbus.addr = st.ch[st.chan].dest_step_select ? st.ch[st.chan].fwd
                                                        : st.ch[st.chan].dst;
        end
    end

    assign bus_req_out = sbus.req;
    assign bus_wr_out = sbus.wr;
    assign bus_addr_out = sbus.addr;
    assign bus_wdata_out = sbus.wdata;
    assign bus_byte_out = sbus.byte_mode;
    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign dma_irq_out = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_disabled_no_start: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_IDLE && next_st.phase == TCSDMA_READ)
        |-> st.ch[next_st.chan].channel_enable)
        else $error("transfer started on disabled channel");
    chk_ch0_first: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (grant_any && ready_ch[0]) |=> (st.chan == 1'b0))
        else $error("channel 1 served ahead of channel 0");
    chk_irq_underflow: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_WRITE && bus_done_in && st.ch[st.chan].count == 16'h0000)
        |=> dma_irq_out[$past(st.chan)])
        else $error("no interrupt at underflow");
    chk_single_stop: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_WRITE && bus_done_in && st.ch[st.chan].count == 16'h0000
         && !st.ch[st.chan].repeat_mode_select && !wr_ctrl[st.chan])
        |=> !st.ch[$past(st.chan)].channel_enable)
        else $error("single mode kept running after underflow");
    chk_repeat_reload: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_WRITE && bus_done_in && st.ch[st.chan].count == 16'h0000
         && st.ch[st.chan].repeat_mode_select && !apb_wr)
        |=> st.ch[$past(st.chan)].count == st.ch[$past(st.chan)].reload)
        else $error("repeat mode did not reload");
    chk_one_unit: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_READ && bus_done_in) |=> st.phase == TCSDMA_WRITE)
        else $error("read not followed by one write");
    chk_soft_bit_zero: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (apb_rd && !st.pready && paddr_in == `TCSDMA_CAUSE0_ADDR)
        |=> prdata_out[7] == 1'b0 && prdata_out[5:4] == 2'b00)
        else $error("cause register upper bits not zero");
    chk_grant_clears: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (grant_any && !grant_ch && !sel_evt[0] && !soft_evt[0])
        |=> !st.ch[0].request_pending_bit)
        else $error("pending latch kept after grant");
    // A stolen cycle hands the bus back after one unit
    chk_steal_release: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (st.phase == TCSDMA_WRITE && bus_done_in) |=> !bus_req_out)
        else $error("bus held past one unit");
    // Interrupt pulses come only from an underflowing write
    chk_irq_cause: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        dma_irq_out[0] |-> $past(st.phase == TCSDMA_WRITE && bus_done_in && !st.chan
        && st.ch[0].count == `TCSDMA_CNT_ZERO))
        else $error("interrupt without underflow");
    // First grant after enable takes the counter from reload
    chk_start_reload: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (grant_any && !grant_ch && st.ch[0].fresh && !apb_wr)
        |=> st.ch[0].count == st.ch[0].reload)
        else $error("counter not loaded at first transfer");
    // Soft bit with extended causes selected raises no request
    chk_soft_code: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        (wr_cause[0] && pwdata_in[`TCSDMA_EXT_BIT] && !sel_evt[0]
         && !st.ch[0].request_pending_bit) |=> !st.ch[0].request_pending_bit)
        else $error("soft request taken with extended causes");

endmodule // tcsdma_core

// file: sim/tcsdma_mem_model.sv
// Memory partner that answers the controller's stolen bus cycles
`timescale 1ns/1ps
module tcsdma_mem_model (
    // Clock, reset and answer delay
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] lat_in,
    // Bus from the controller
    input wire logic bus_req_in,
    input wire logic [19:0] bus_addr_in,
    output logic bus_grant_out,
    output logic bus_done_out,
    output logic [15:0] bus_rdata_out
);
    logic [1:0] wait_cnt;
    // Controller always wins the bus over the cpu
    assign bus_grant_out = bus_req_in;
    // One done pulse per phase; read data toggles away from the pulse
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_cnt <= 2'h0;
            bus_done_out <= 1'b0;
            bus_rdata_out <= 16'hffff;
        end else begin
            bus_done_out <= 1'b0;
            bus_rdata_out <= ~bus_rdata_out;
            if (bus_req_in && !bus_done_out) begin
                if (wait_cnt == lat_in) begin
                    wait_cnt <= 2'h0;
                    bus_done_out <= 1'b1;
                    bus_rdata_out <= bus_addr_in[15:0] ^ 16'h5a5a;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule // tcsdma_mem_model

// file: sim/tb_tcsdma_core.sv
// Self-checking bench for the two-channel cycle-steal controller
`timescale 1ns/1ps
`include "tcsdma_defs.svh"
module tb_tcsdma_core;
    import tcsdma_pkg::*;
    // Register row: address, write, data, expected read, error
    typedef struct packed {
        logic [13:0] addr;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic err;
    } tcsdma_row_type;
    logic ref_clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, rerr;
    logic req, wr, byte_u, grant, done;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] b0, e0, b1, e1, wdata, rdata;
    logic [19:0] addr;
    logic [1:0] irq, lat;
    int num_errors = 0;
    int n_tests = 0;
    int irq0 = 0;
    int irq1 = 0;
    logic [19:0] wq[$];
    logic [15:0] dq[$];
    logic bq[$];
    tcsdma_row_type rows[10];

    always #2.5 ref_clk_in = ~ref_clk_in;

    tcsdma_core dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ch0_basic_in(b0), .ch0_ext_in(e0), .ch1_basic_in(b1), .ch1_ext_in(e1),
        .bus_req_out(req), .bus_wr_out(wr), .bus_addr_out(addr), .bus_wdata_out(wdata),
        .bus_byte_out(byte_u), .bus_grant_in(grant), .bus_done_in(done),
        .bus_rdata_in(rdata), .dma_irq_out(irq));
    tcsdma_mem_model mem (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .lat_in(lat),
        .bus_req_in(req), .bus_addr_in(addr), .bus_grant_out(grant), .bus_done_out(done),
        .bus_rdata_out(rdata));

    // Log completed writes and interrupt pulses
    always @(posedge ref_clk_in) begin
        if (done === 1'b1 && wr === 1'b1) begin
            wq.push_back(addr);
            dq.push_back(wdata);
            bq.push_back(byte_u);
        end
        if (irq[0] === 1'b1) irq0++;
        if (irq[1] === 1'b1) irq1++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic [13:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_in);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no pready answer", $time);
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for n logged writes, then let the cycle settle
    task automatic wait_wr(input int n);
        for (int k = 0; k < 300 && wq.size() < n; k++) @(posedge ref_clk_in);
        repeat (6) @(posedge ref_clk_in);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: whole run needs well under 20000 cycles
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        {ref_clk_in, reset_n_in, psel, penable, pwrite} = 5'h00;
        {paddr, pwdata, b0, e0, b1, e1, lat} = '0;
        rows = '{'{`TCSDMA_CAUSE0_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
            '{`TCSDMA_CTRL0_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
            '{`TCSDMA_CNT0_ADDR, 1'b0, 32'h0, 32'h0, 1'b0},
            '{`TCSDMA_CAUSE0_ADDR, 1'b1, 32'hff, 32'h0, 1'b0},
            '{`TCSDMA_CAUSE0_ADDR, 1'b0, 32'h0, 32'h4f, 1'b0},
            '{`TCSDMA_CTRL1_ADDR, 1'b1, 32'h13, 32'h0, 1'b0},
            '{`TCSDMA_CTRL1_ADDR, 1'b0, 32'h0, 32'h13, 1'b0},
            '{`TCSDMA_RLD0_ADDR, 1'b1, 32'h12345, 32'h0, 1'b0},
            '{`TCSDMA_RLD0_ADDR, 1'b0, 32'h0, 32'h2345, 1'b0},
            '{14'h0ffc, 1'b0, 32'h0, 32'h0, 1'b1}};
        repeat (5) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].addr, rows[i].wr, rows[i].wdata);
            if (!rows[i].wr) chk(rd, rows[i].exp);
            chk({31'h0, rerr}, {31'h0, rows[i].err});
        end
        $display("register rows done");
        // Soft requests, single mode, word units, stepping source only
        lat <= 2'h2;
        apb(`TCSDMA_SRC0_ADDR, 1'b1, 32'h10000);
        apb(`TCSDMA_DST0_ADDR, 1'b1, 32'h00400);
        apb(`TCSDMA_RLD0_ADDR, 1'b1, 32'h1);
        apb(`TCSDMA_CTRL0_ADDR, 1'b1, 32'h18);
        apb(`TCSDMA_CAUSE0_ADDR, 1'b1, 32'hc1);
        wait_wr(1);
        chk(wq.size(), 0);
        apb(`TCSDMA_CAUSE0_ADDR, 1'b1, 32'h81);
        wait_wr(1);
        chk(irq0, 0);
        apb(`TCSDMA_CAUSE0_ADDR, 1'b1, 32'h81);
        wait_wr(2);
        chk(wq[0], 20'h00400);
        chk(dq[0], 16'h5a5a);
        chk(wq[1], 20'h00400);
        chk(dq[1], 16'h5a58);
        chk(bq[0], 1'b0);
        chk(irq0, 1);
        apb(`TCSDMA_SRC0_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h10004);
        apb(`TCSDMA_CTRL0_ADDR, 1'b0, 32'h0);
        chk(rd & 32'h8, 32'h0);
        apb(`TCSDMA_CAUSE0_ADDR, 1'b1, 32'h81);
        wait_wr(3);
        chk(wq.size(), 2);
        $display("single mode test done");
        // Both channels requested at once by peripheral lines, both sides fixed
        lat <= 2'h0;
        wq.delete();
        bq.delete();
        apb(`TCSDMA_DST0_ADDR, 1'b1, 32'h00800);
        apb(`TCSDMA_RLD0_ADDR, 1'b1, 32'h0);
        apb(`TCSDMA_CAUSE0_ADDR, 1'b1, 32'h47);
        apb(`TCSDMA_CTRL0_ADDR, 1'b1, 32'h08);
        apb(`TCSDMA_DST1_ADDR, 1'b1, 32'h00900);
        apb(`TCSDMA_RLD1_ADDR, 1'b1, 32'h0);
        apb(`TCSDMA_CAUSE1_ADDR, 1'b1, 32'h02);
        apb(`TCSDMA_CTRL1_ADDR, 1'b1, 32'h0b);
        e0[7] <= 1'b1;
        b1[2] <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        {e0, b1} <= 32'h0;
        wait_wr(2);
        chk(wq[0], 20'h00800);
        chk(wq[1], 20'h00900);
        chk({bq[0], bq[1]}, 2'b01);
        chk(irq0 * 4 + irq1, 32'h9);
        b1[2] <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        b1 <= 16'h0;
        wait_wr(3);
        chk(wq.size(), 3);
        apb(`TCSDMA_CTRL1_ADDR, 1'b0, 32'h0);
        chk(rd & 32'h8, 32'h8);
        $display("priority and repeat test done");
        // Reset in mid-run returns registers to zero
        reset_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        apb(`TCSDMA_CTRL1_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        report_and_stop();
    end
endmodule // tb_tcsdma_core
